/* verification/swc_core_model.sv */
// behavioural processor core model driving the sleep and wake block
`timescale 1ns/1ns
module swc_core_model #(
  parameter int unsigned IO_W = 6
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cpu_clk_en,
  output logic sleep_exec,
  output logic clrwdt_exec,
  output logic global_irq_enable,
  output logic other_irq_pending,
  output logic [IO_W-1:0] io_out_in,
  output logic [IO_W-1:0] io_oe_in
);
  initial
  begin
    sleep_exec = 1'b0;
    clrwdt_exec = 1'b0;
    global_irq_enable = 1'b0;
    other_irq_pending = 1'b0;
  end

  // pin drive moves every cycle, even asleep, so a leaky hold shows up
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      io_out_in <= '0;
      io_oe_in <= '0;
    end
    else
    begin
      io_out_in <= io_out_in + 1'b1;
      io_oe_in <= ~io_oe_in;
    end
  end

  task automatic set_gie(input logic val);
    @(posedge core_clk);
    global_irq_enable <= val;
  endtask

  // one-cycle sleep strobe; reports the pin drive latched just before it
  task automatic exec_sleep(output logic [IO_W-1:0] io_seen, output logic [IO_W-1:0] oe_seen);
    @(posedge core_clk);
    // read before this edge's update lands: the drive the pins show in the sleep cycle
    io_seen = io_out_in;
    oe_seen = io_oe_in;
    sleep_exec <= 1'b1;
    @(posedge core_clk);
    sleep_exec <= 1'b0;
  endtask
endmodule

/* verification/test_sleep_wake_control.sv */
// self-checking bench for the sleep and wake control block
`timescale 1ns/1ns
module test_sleep_wake_control;
  import swc_pkg::*;
  logic core_clk, resetn, reg_wr, reg_rd, ext_irq_pin, master_clear_pin_n;
  logic brownout_reset, adc_dedicated_osc, sleep_exec, clrwdt_exec;
  logic global_irq_enable, other_irq_pending, cpu_clk_en, lf_tick, adc_clk_en;
  logic regulator_low_power, sleeping, powerdown_flag, timeout_flag, prefetch_next;
  logic resume_pulse, isr_call, watchdog_clear, watchdog_reset, device_reset;
  logic wd_seen, rst_seen;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd_val;
  logic [5:0] ev, io_out_in, io_oe_in, io_out, io_oe, io_seen, oe_seen;
  logic [15:0] isr_vector;
  int num_errors, total_checks, n, ticks;

  swc_sleep_ctrl #(.IO_W(6), .WDT_TICKS(4)) dut (.core_clk(core_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sleep_exec(sleep_exec), .clrwdt_exec(clrwdt_exec),
    .global_irq_enable(global_irq_enable), .other_irq_pending(other_irq_pending),
    .ext_irq_pin(ext_irq_pin), .master_clear_pin_n(master_clear_pin_n),
    .brownout_reset(brownout_reset), .adc_dedicated_osc(adc_dedicated_osc),
    .comparator_two_event(ev[0]), .comparator_one_event(ev[1]),
    .bus_collision_event(ev[2]), .numeric_osc_event(ev[3]),
    .logic_cell_two_event(ev[4]), .logic_cell_one_event(ev[5]),
    .io_out_in(io_out_in), .io_oe_in(io_oe_in), .io_out(io_out), .io_oe(io_oe),
    .cpu_clk_en(cpu_clk_en), .low_freq_internal_osc_tick(lf_tick),
    .adc_clk_en(adc_clk_en), .regulator_low_power(regulator_low_power),
    .sleeping(sleeping), .powerdown_flag(powerdown_flag), .timeout_flag(timeout_flag),
    .prefetch_next(prefetch_next), .resume_pulse(resume_pulse), .isr_call(isr_call),
    .isr_vector(isr_vector), .watchdog_clear(watchdog_clear),
    .watchdog_reset(watchdog_reset), .device_reset(device_reset));

  swc_core_model #(.IO_W(6)) core (.core_clk(core_clk), .resetn(resetn),
    .cpu_clk_en(cpu_clk_en), .sleep_exec(sleep_exec), .clrwdt_exec(clrwdt_exec),
    .global_irq_enable(global_irq_enable), .other_irq_pending(other_irq_pending),
    .io_out_in(io_out_in), .io_oe_in(io_oe_in));

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [3:0] addr, input logic [7:0] data);
    @(posedge core_clk);
    reg_addr <= addr;
    reg_wdata <= data;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] addr, output logic [7:0] data);
    @(posedge core_clk);
    reg_addr <= addr;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    data = reg_rdata;
  endtask

  task automatic pulse_ev(input int idx);
    @(posedge core_clk);
    ev[idx] <= 1'b1;
    @(posedge core_clk);
    ev[idx] <= 1'b0;
  endtask

  task automatic do_sleep();
    core.exec_sleep(io_seen, oe_seen);
    #1;
    check("prefetch_next", 1'b1, prefetch_next);
  endtask

  // bounded wait for the clock to come back; notes wake side effects on the way
  task automatic wait_resume(input int lim, output int cnt);
    cnt = 0;
    wd_seen = 1'b0;
    rst_seen = 1'b0;
    ticks = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      cnt++;
      wd_seen |= watchdog_clear;
      rst_seen |= device_reset;
      ticks += int'(lf_tick);
    end while (resume_pulse !== 1'b1 && cnt < lim);
    if (resume_pulse !== 1'b1)
    begin
      num_errors++;
      $display("unexpected resume_pulse expected 1 seen %b", resume_pulse);
      finish_test();
    end
  endtask

  task automatic t_regs();
    logic [3:0] ad [6] = '{ADDR_FLAGS2, ADDR_FLAGS3, ADDR_ENABLE2, ADDR_ENABLE3, ADDR_CONTROL, 4'hF};
    logic [7:0] rv [6] = '{FLAGS_RST, FLAGS_RST, ENABLE_RST, ENABLE_RST, CTRL_RST, 8'h00};
    logic [7:0] mk [6] = '{FLAGS2_MASK, FLAGS3_MASK, FLAGS2_MASK, FLAGS3_MASK, CTRL_MASK, 8'h00};
    for (int i = 0; i < 6; i++)
    begin
      reg_read(ad[i], rd_val);
      check("reset value", {8'h00, rv[i]}, {8'h00, rd_val});
      reg_write(ad[i], 8'hFF);
      reg_read(ad[i], rd_val);
      check("masked value", {8'h00, mk[i]}, {8'h00, rd_val});
      reg_write(ad[i], 8'h00);
      reg_read(ad[i], rd_val);
      check("cleared value", 16'h0000, {8'h00, rd_val});
    end
    reg_write(ADDR_CONTROL, CTRL_RST);
    reg_write(ADDR_STATUS, 8'h00);
    reg_read(ADDR_STATUS, rd_val);
    check("status", 16'h0003, {8'h00, rd_val});
  endtask

  task automatic t_events_noop();
    for (int i = 0; i < 6; i++)
      pulse_ev(i);
    reg_read(ADDR_FLAGS2, rd_val);
    check("flags2", {8'h00, FLAGS2_MASK}, {8'h00, rd_val});
    reg_read(ADDR_FLAGS3, rd_val);
    check("flags3", {8'h00, FLAGS3_MASK}, {8'h00, rd_val});
    reg_write(ADDR_ENABLE2, 8'h40);
    do_sleep();
    check("cpu_clk_en", 1'b1, cpu_clk_en);
    check("powerdown_flag", 1'b1, powerdown_flag);
    check("timeout_flag", 1'b1, timeout_flag);
    check("watchdog_clear", 1'b0, watchdog_clear);
  endtask

  task automatic t_irq_wake();
    reg_write(ADDR_FLAGS2, 8'h00);
    reg_write(ADDR_FLAGS3, 8'h00);
    core.set_gie(1'b1);
    adc_dedicated_osc <= 1'b1;
    do_sleep();
    check("cpu_clk_en", 1'b0, cpu_clk_en);
    check("powerdown_flag", 1'b0, powerdown_flag);
    check("timeout_flag", 1'b1, timeout_flag);
    check("watchdog_clear", 1'b1, watchdog_clear);
    pulse_ev(1);
    repeat (4) @(posedge core_clk);
    #1;
    check("sleeping", 1'b1, sleeping);
    check("adc_clk_en", 1'b1, adc_clk_en);
    check("io_out", {10'h000, io_seen}, {10'h000, io_out});
    check("io_oe", {10'h000, oe_seen}, {10'h000, io_oe});
    pulse_ev(0);
    wait_resume(10, n);
    check("normal wake time", 1'b1, n <= 5);
    check("wake watchdog_clear", 1'b1, wd_seen);
    check("wake device_reset", 1'b0, rst_seen);
    @(posedge core_clk);
    #1;
    check("isr_call", 1'b1, isr_call);
    check("isr_vector", 16'h0004, isr_vector);
    reg_read(ADDR_FLAGS2, rd_val);
    check("flags2 kept", 16'h0060, {8'h00, rd_val});
  endtask

  task automatic t_lp_wake();
    reg_write(ADDR_FLAGS2, 8'h00);
    reg_write(ADDR_ENABLE3, 8'h01);
    reg_write(ADDR_CONTROL, 8'h31);
    core.set_gie(1'b0);
    adc_dedicated_osc <= 1'b0;
    do_sleep();
    repeat (2) @(posedge core_clk);
    #1;
    check("regulator_low_power", 1'b1, regulator_low_power);
    check("adc_clk_en", 1'b0, adc_clk_en);
    pulse_ev(5);
    wait_resume(700, n);
    check("low power wake time", 1'b1, n >= 500);
    @(posedge core_clk);
    #1;
    check("isr_call", 1'b0, isr_call);
    check("regulator_low_power", 1'b0, regulator_low_power);
  endtask

  task automatic t_wdt_wake();
    reg_write(ADDR_FLAGS3, 8'h00);
    reg_write(ADDR_CONTROL, 8'h36);
    do_sleep();
    wait_resume(20000, n);
    check("lf ticks in sleep", 1'b1, ticks >= 4);
    check("timeout_flag", 1'b0, timeout_flag);
    check("powerdown_flag", 1'b0, powerdown_flag);
    check("wdt device_reset", 1'b0, rst_seen);
    reg_write(ADDR_CONTROL, CTRL_RST);
  endtask

  // external pin wake, then watchdog expiry while awake
  task automatic t_ext_wdt_awake();
    reg_write(ADDR_CONTROL, 8'h38);
    do_sleep();
    @(posedge core_clk);
    ext_irq_pin <= 1'b1;
    wait_resume(10, n);
    check("ext wake device_reset", 1'b0, rst_seen);
    check("ext wake watchdog_clear", 1'b1, wd_seen);
    check("ext wake timeout_flag", 1'b1, timeout_flag);
    @(posedge core_clk);
    ext_irq_pin <= 1'b0;
    reg_write(ADDR_CONTROL, 8'h32);
    n = 0;
    while (watchdog_reset !== 1'b1 && n < 20000)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check("watchdog_reset", 1'b1, watchdog_reset);
    if (watchdog_reset !== 1'b1)
      finish_test();
    check("awake device_reset", 1'b0, device_reset);
    @(posedge core_clk);
    #1;
    check("awake timeout_flag", 1'b0, timeout_flag);
    reg_write(ADDR_CONTROL, CTRL_RST);
  endtask

  task automatic t_full_reset();
    for (int src = 0; src < 2; src++)
    begin
      reg_write(ADDR_CONTROL, 8'h31);
      do_sleep();
      @(posedge core_clk);
      if (src == 0)
        master_clear_pin_n <= 1'b0;
      else
        brownout_reset <= 1'b1;
      n = 0;
      while (device_reset !== 1'b1 && n < 10)
      begin
        @(posedge core_clk);
        #1;
        n++;
      end
      check("device_reset", 1'b1, device_reset);
      if (device_reset !== 1'b1)
        finish_test();
      @(posedge core_clk);
      master_clear_pin_n <= 1'b1;
      brownout_reset <= 1'b0;
      repeat (6) @(posedge core_clk);
      #1;
      check("cpu_clk_en", 1'b1, cpu_clk_en);
      reg_read(ADDR_CONTROL, rd_val);
      check("control restored", {8'h00, CTRL_RST}, {8'h00, rd_val});
      reg_read(ADDR_STATUS, rd_val);
      check("status restored", 16'h0003, {8'h00, rd_val});
    end
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial
  begin
    resetn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ext_irq_pin = 1'b0;
    master_clear_pin_n = 1'b1;
    brownout_reset = 1'b0;
    adc_dedicated_osc = 1'b0;
    ev = 6'h00;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    t_regs();
    t_events_noop();
    t_irq_wake();
    t_lp_wake();
    t_wdt_wake();
    t_ext_wdt_awake();
    t_full_reset();
    finish_test();
  end
endmodule

/* verilog/swc_pkg.sv */
// constants for the sleep and wake control block
package swc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CORE_CLK_HZ = 100_000_000;
  localparam int unsigned LFOSC_HZ = 31_000;
  localparam int unsigned LF_DIV_CYC = CORE_CLK_HZ / LFOSC_HZ;
  localparam int unsigned LP_WAKE_TIME_NS = 5000;
  localparam int unsigned LP_WAKE_CYC = (LP_WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned NORMAL_WAKE_CYC = 1;
  localparam int unsigned WDT_PERIOD_TICKS = 62000;
  localparam int unsigned WAKE_CNT_W = 10;
  localparam int unsigned LF_DIV_W = 12;

  localparam logic [3:0] ADDR_FLAGS2 = 4'h0;
  localparam logic [3:0] ADDR_FLAGS3 = 4'h1;
  localparam logic [3:0] ADDR_ENABLE2 = 4'h2;
  localparam logic [3:0] ADDR_ENABLE3 = 4'h3;
  localparam logic [3:0] ADDR_CONTROL = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;

  localparam int unsigned BIT_CMP2 = 6;
  localparam int unsigned BIT_CMP1 = 5;
  localparam int unsigned BIT_BUSCOL = 3;
  localparam int unsigned BIT_NCO = 2;
  localparam int unsigned BIT_CLC2 = 1;
  localparam int unsigned BIT_CLC1 = 0;
  localparam logic [7:0] FLAGS2_MASK = 8'h6C;
  localparam logic [7:0] FLAGS3_MASK = 8'h03;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] ENABLE_RST = 8'h00;

  localparam int unsigned CTRL_LP_SLEEP = 0;
  localparam int unsigned CTRL_WDT_EN = 1;
  localparam int unsigned CTRL_WDT_IN_SLEEP = 2;
  localparam int unsigned CTRL_EXT_IRQ_EN = 3;
  localparam int unsigned CTRL_MASTER_CLEAR_PIN_EN = 4;
  localparam int unsigned CTRL_BOR_EN = 5;
  localparam logic [7:0] CTRL_MASK = 8'h3F;
  localparam logic [7:0] CTRL_RST = 8'h30;

  localparam int unsigned STAT_PD = 0;
  localparam int unsigned STAT_TO = 1;
  localparam int unsigned STAT_SLEEP = 2;
  localparam logic PD_RST = 1'b1;
  localparam logic TO_RST = 1'b1;

  localparam logic [15:0] ISR_VECTOR = 16'h0004;

  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_SLEEP = 3'h1,
    ST_WAKE_WAIT = 3'h2,
    ST_EXEC_NEXT = 3'h3
  } swc_state_type;
endpackage

/* verilog/swc_sleep_ctrl.sv */
// sleep entry, wake-up control and peripheral flag registers
//
// How it works
// [R1] sleep is entered only by the sleep instruction strobe
// [R2] entering sleep clears watchdog; it counts in sleep only if so configured
// [R3] entering sleep clears powerdown flag, sets timeout flag, stops cpu clock
// [R4] low-frequency oscillator tick keeps running during sleep
// [R5] adc clock keeps running in sleep when using its dedicated oscillator
// [R6] io pins hold their pre-sleep drive state during sleep
// [R7] non-watchdog resets act identically asleep or awake
// [R8] master clear, brownout or power-on wake gives full device reset
// [R9] watchdog or interrupt wake resumes execution without reset
// [R10] sleep instruction prefetches the next instruction
// [R11] interrupt wakes only if its enable is set, regardless of global enable
// [R12] after interrupt wake run prefetched instruction, then isr if global enable
// [R13] isr vector is address 0004h
// [R14] watchdog is cleared on every wake from sleep
// [R15] pending enabled interrupt before sleep makes sleep a no-op
// [R16] flag set during sleep wakes at once with normal sleep flag effects
// [R17] powerdown flag stays set after a no-op sleep
// [R18] peripheral flags set on events regardless of any enable
// [R19] software should clear flags before enabling interrupts
// [R20] flags2: cmp2 bit6, cmp1 bit5, buscol bit3, nco bit2; rest zero
// [R21] flags3: logic cell2 bit1, logic cell1 bit0; bits 7-2 read zero
// [R22] low-power select puts regulator in low-power state during sleep
// [R23] low-power sleep adds extra stabilisation delay on wake
// [R24] flags clear only by software writing zero or by a full device reset
`timescale 1ns/1ns
module swc_sleep_ctrl
#(
  parameter int unsigned IO_W = 6,
  parameter int unsigned WDT_TICKS = swc_pkg::WDT_PERIOD_TICKS
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sleep_exec,
  input wire logic clrwdt_exec,
  input wire logic global_irq_enable,
  input wire logic other_irq_pending,
  input wire logic ext_irq_pin,
  input wire logic master_clear_pin_n,
  input wire logic brownout_reset,
  input wire logic adc_dedicated_osc,
  input wire logic comparator_two_event,
  input wire logic comparator_one_event,
  input wire logic bus_collision_event,
  input wire logic numeric_osc_event,
  input wire logic logic_cell_two_event,
  input wire logic logic_cell_one_event,
  input wire logic [IO_W-1:0] io_out_in,
  input wire logic [IO_W-1:0] io_oe_in,
  output logic [IO_W-1:0] io_out,
  output logic [IO_W-1:0] io_oe,
  output logic cpu_clk_en,
  output logic low_freq_internal_osc_tick,
  output logic adc_clk_en,
  output logic regulator_low_power,
  output logic sleeping,
  output logic powerdown_flag,
  output logic timeout_flag,
  output logic prefetch_next,
  output logic resume_pulse,
  output logic isr_call,
  output logic [15:0] isr_vector,
  output logic watchdog_clear,
  output logic watchdog_reset,
  output logic device_reset
);
  import swc_pkg::*;

  localparam int unsigned WDT_W = $clog2(WDT_TICKS + 1);
  localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WDT_TICKS - 1);
  localparam logic [LF_DIV_W-1:0] LF_LAST = LF_DIV_W'(LF_DIV_CYC - 1);
  localparam logic [WAKE_CNT_W-1:0] LP_WAIT = WAKE_CNT_W'(LP_WAKE_CYC - 1);
  localparam logic [WAKE_CNT_W-1:0] NORMAL_WAIT = WAKE_CNT_W'(NORMAL_WAKE_CYC - 1);

  typedef struct packed {
    swc_state_type st;
    logic [7:0] flags2;
    logic [7:0] flags3;
    logic [7:0] en2;
    logic [7:0] en3;
    logic [7:0] ctrl;
    logic pd;
    logic to;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [LF_DIV_W-1:0] lf_div;
    logic lf_tick;
    logic [WDT_W-1:0] wdt_cnt;
    logic [WAKE_CNT_W-1:0] wake_cnt;
    logic irq_wake;
    logic [7:0] rdata;
    logic cpu_clk_en;
    logic adc_clk_en;
    logic reg_lp;
    logic [IO_W-1:0] io_out;
    logic [IO_W-1:0] io_oe;
    logic prefetch;
    logic resume;
    logic isr_call;
    logic wdt_clear;
    logic wdt_reset;
    logic dev_reset;
    logic sleep_state;
  } swc_regs_type;

  swc_regs_type r_reg;
  swc_regs_type r_next;

  logic [7:0] evt2;
  logic [7:0] evt3;
  logic irq_pending;
  logic full_reset_req;
  logic asleep;
  logic wdt_active;
  logic wdt_expire;
  logic [7:0] rd_value;

  assign evt2 = {1'b0, comparator_two_event, comparator_one_event, 1'b0,
                 bus_collision_event, numeric_osc_event, 2'b00};
  assign evt3 = {6'b000000, logic_cell_two_event, logic_cell_one_event};
  // enabled sources only, global enable deliberately ignored
  assign irq_pending = (|(r_reg.flags2 & r_reg.en2 & FLAGS2_MASK))  // R11
    | (|(r_reg.flags3 & r_reg.en3 & FLAGS3_MASK))
    | other_irq_pending
    | (r_reg.sync2[2] & r_reg.ctrl[CTRL_EXT_IRQ_EN]);
  // same reset path whether asleep or awake
  assign full_reset_req = (r_reg.sync2[0] & r_reg.ctrl[CTRL_MASTER_CLEAR_PIN_EN])  // R7
    | (r_reg.sync2[1] & r_reg.ctrl[CTRL_BOR_EN]);
  assign asleep = (r_reg.st == ST_SLEEP) || (r_reg.st == ST_WAKE_WAIT);
  assign wdt_active = r_reg.ctrl[CTRL_WDT_EN] & (~asleep | r_reg.ctrl[CTRL_WDT_IN_SLEEP]);  // R2
  assign wdt_expire = wdt_active & r_reg.lf_tick & (r_reg.wdt_cnt == WDT_LAST);

  always_comb
  begin
    case (reg_addr)
      ADDR_FLAGS2: rd_value = r_reg.flags2 & FLAGS2_MASK;  // R20
      ADDR_FLAGS3: rd_value = r_reg.flags3 & FLAGS3_MASK;  // R21
      ADDR_ENABLE2: rd_value = r_reg.en2;
      ADDR_ENABLE3: rd_value = r_reg.en3;
      ADDR_CONTROL: rd_value = r_reg.ctrl;
      ADDR_STATUS: rd_value = {5'b00000, asleep, r_reg.to, r_reg.pd};
      default: rd_value = 8'h00;
    endcase
  end

  always_comb
  begin
    r_next = r_reg;
    r_next.prefetch = 1'b0;
    r_next.resume = 1'b0;
    r_next.isr_call = 1'b0;
    r_next.wdt_clear = 1'b0;
    r_next.wdt_reset = 1'b0;
    r_next.dev_reset = 1'b0;
    r_next.rdata = reg_rd ? rd_value : 8'h00;
    r_next.sync1 = {ext_irq_pin, brownout_reset, ~master_clear_pin_n};
    r_next.sync2 = r_reg.sync1;

    // free-running low-frequency tick, unaffected by sleep
    if (r_reg.lf_div == LF_LAST)  // R4
    begin
      r_next.lf_div = '0;
      r_next.lf_tick = 1'b1;
    end
    else
    begin
      r_next.lf_div = r_reg.lf_div + 1'b1;
      r_next.lf_tick = 1'b0;
    end

    // software writes, then hardware sets win over a clear
    if (reg_wr)
    begin
      case (reg_addr)
        ADDR_FLAGS2: r_next.flags2 = reg_wdata & FLAGS2_MASK;  // R24
        ADDR_FLAGS3: r_next.flags3 = reg_wdata & FLAGS3_MASK;  // R24
        ADDR_ENABLE2: r_next.en2 = reg_wdata & FLAGS2_MASK;
        ADDR_ENABLE3: r_next.en3 = reg_wdata & FLAGS3_MASK;
        ADDR_CONTROL: r_next.ctrl = reg_wdata & CTRL_MASK;
        default: r_next.ctrl = r_next.ctrl;
      endcase
    end
    r_next.flags2 = r_next.flags2 | evt2;  // R18
    r_next.flags3 = r_next.flags3 | evt3;  // R18

    // watchdog count on low-frequency ticks
    if (!wdt_active || clrwdt_exec)
      r_next.wdt_cnt = '0;
    else if (wdt_expire)
      r_next.wdt_cnt = '0;
    else if (r_reg.lf_tick)
      r_next.wdt_cnt = r_reg.wdt_cnt + 1'b1;

    case (r_reg.st)
      ST_RUN:
      begin
        r_next.cpu_clk_en = 1'b1;
        r_next.io_out = io_out_in;
        r_next.io_oe = io_oe_in;
        if (wdt_expire)
        begin
          r_next.wdt_reset = 1'b1;
          r_next.to = 1'b0;
        end
        if (sleep_exec)  // R1
        begin
          r_next.prefetch = 1'b1;  // R10
          if (!irq_pending)  // R15 R17
          begin
            r_next.st = ST_SLEEP;
            r_next.pd = 1'b0;  // R3
            r_next.to = 1'b1;  // R3
            r_next.cpu_clk_en = 1'b0;  // R3
            r_next.wdt_cnt = '0;  // R2
            r_next.wdt_clear = 1'b1;  // R2
            r_next.io_out = r_reg.io_out;  // R6
            r_next.io_oe = r_reg.io_oe;  // R6
          end
        end
      end
      ST_SLEEP:
      begin
        if (irq_pending || wdt_expire)  // R16
        begin
          r_next.st = ST_WAKE_WAIT;
          r_next.irq_wake = irq_pending;
          if (!irq_pending)
            r_next.to = 1'b0;
          r_next.wdt_cnt = '0;  // R14
          r_next.wdt_clear = 1'b1;  // R14
          r_next.wake_cnt = r_reg.ctrl[CTRL_LP_SLEEP] ? LP_WAIT : NORMAL_WAIT;  // R23
        end
      end
      ST_WAKE_WAIT:
      begin
        if (r_reg.wake_cnt == '0)
        begin
          r_next.st = ST_EXEC_NEXT;
          r_next.cpu_clk_en = 1'b1;  // R9
          r_next.resume = 1'b1;
        end
        else
          r_next.wake_cnt = r_reg.wake_cnt - 1'b1;
      end
      ST_EXEC_NEXT:
      begin
        // prefetched instruction runs this cycle
        r_next.st = ST_RUN;
        r_next.isr_call = r_reg.irq_wake & global_irq_enable;  // R12
        r_next.irq_wake = 1'b0;
      end
      default:
        r_next.st = ST_RUN;
    endcase

    r_next.adc_clk_en = r_next.cpu_clk_en | adc_dedicated_osc;  // R5
    r_next.reg_lp = (r_next.st == ST_SLEEP || r_next.st == ST_WAKE_WAIT)
      & r_next.ctrl[CTRL_LP_SLEEP];  // R22

    if (full_reset_req)  // R8
    begin
      r_next.st = ST_RUN;
      r_next.dev_reset = 1'b1;
      r_next.flags2 = FLAGS2_MASK & evt2;
      r_next.flags3 = FLAGS3_MASK & evt3;
      r_next.en2 = ENABLE_RST;
      r_next.en3 = ENABLE_RST;
      r_next.ctrl = CTRL_RST;
      r_next.pd = PD_RST;
      r_next.to = TO_RST;
      r_next.wdt_cnt = '0;
      r_next.irq_wake = 1'b0;
      r_next.cpu_clk_en = 1'b1;
      r_next.adc_clk_en = 1'b1;
      r_next.reg_lp = 1'b0;
      r_next.isr_call = 1'b0;
      r_next.prefetch = 1'b0;
      r_next.resume = 1'b0;
    end
    r_next.sleep_state = (r_next.st == ST_SLEEP) || (r_next.st == ST_WAKE_WAIT);
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      r_reg <= '0;
      r_reg.st <= ST_RUN;
      r_reg.flags2 <= FLAGS_RST;
      r_reg.flags3 <= FLAGS_RST;
      r_reg.en2 <= ENABLE_RST;
      r_reg.en3 <= ENABLE_RST;
      r_reg.ctrl <= CTRL_RST;
      r_reg.pd <= PD_RST;
      r_reg.to <= TO_RST;
      r_reg.cpu_clk_en <= 1'b1;
      r_reg.adc_clk_en <= 1'b1;
    end
    else
      r_reg <= r_next;
  end

  assign reg_rdata = r_reg.rdata;
  assign io_out = r_reg.io_out;
  assign io_oe = r_reg.io_oe;
  assign cpu_clk_en = r_reg.cpu_clk_en;
  assign low_freq_internal_osc_tick = r_reg.lf_tick;
  assign adc_clk_en = r_reg.adc_clk_en;
  assign regulator_low_power = r_reg.reg_lp;
  assign sleeping = r_reg.sleep_state;
  assign powerdown_flag = r_reg.pd;
  assign timeout_flag = r_reg.to;
  assign prefetch_next = r_reg.prefetch;
  assign resume_pulse = r_reg.resume;
  assign isr_call = r_reg.isr_call;
  assign isr_vector = ISR_VECTOR;  // R13
  assign watchdog_clear = r_reg.wdt_clear;
  assign watchdog_reset = r_reg.wdt_reset;
  assign device_reset = r_reg.dev_reset;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  logic go_sleep;
  assign go_sleep = sleep_exec && r_reg.st == ST_RUN && !irq_pending && !full_reset_req;

  property p_sleep_only_instr;
    $rose(r_reg.st == ST_SLEEP) |-> $past(sleep_exec);
  endproperty
  a_sleep_only_instr: assert property (p_sleep_only_instr)  // R1
    else $error("sleep entered without sleep instruction");
  property p_enter_flags;
    go_sleep |=> !powerdown_flag && timeout_flag && !cpu_clk_en && watchdog_clear;
  endproperty
  a_enter_flags: assert property (p_enter_flags)  // R3
    else $error("sleep entry flags or clock wrong");
  property p_noop_sleep;
    sleep_exec && r_reg.st == ST_RUN && irq_pending && !full_reset_req
      |=> r_reg.st == ST_RUN && $stable(powerdown_flag) && $stable(timeout_flag)
      && !watchdog_clear;
  endproperty
  a_noop_sleep: assert property (p_noop_sleep)  // R15
    else $error("no-op sleep changed state");
  property p_wake_irq;
    r_reg.st == ST_SLEEP && irq_pending && !full_reset_req
      |=> r_reg.st == ST_WAKE_WAIT && watchdog_clear;
  endproperty
  a_wake_irq: assert property (p_wake_irq)  // R16
    else $error("enabled flag did not wake or clear watchdog");
  property p_flag_set;
    comparator_two_event && !full_reset_req |=> r_reg.flags2[BIT_CMP2];
  endproperty
  a_flag_set: assert property (p_flag_set)  // R18
    else $error("peripheral flag not set by event");
  property p_unused_zero;
    (r_reg.flags2 & ~FLAGS2_MASK) == 8'h00 && (r_reg.flags3 & ~FLAGS3_MASK) == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero)  // R20
    else $error("unused flag bits not zero");
  property p_full_reset;
    full_reset_req |=> device_reset && r_reg.st == ST_RUN && powerdown_flag;
  endproperty
  a_full_reset: assert property (p_full_reset)  // R8
    else $error("reset wake not full reset");
  property p_isr_after_prefetch;
    r_reg.st == ST_EXEC_NEXT && r_reg.irq_wake && global_irq_enable && !full_reset_req
      |=> isr_call && $past(resume_pulse);
  endproperty
  a_isr_after_prefetch: assert property (p_isr_after_prefetch)  // R12
    else $error("isr call missing after interrupt wake");

  property p_lp_delay;
    $rose(r_reg.st == ST_WAKE_WAIT) && r_reg.ctrl[CTRL_LP_SLEEP] |-> (!cpu_clk_en) [*8];
  endproperty
  a_lp_delay: assert property (p_lp_delay)  // R23
    else $error("low-power wake too fast");

  property p_io_hold;
    sleeping && $past(sleeping) |-> $stable(io_out) && $stable(io_oe);
  endproperty
  a_io_hold: assert property (p_io_hold)  // R6
    else $error("io changed during sleep");

  c_real_sleep: cover property (go_sleep ##1 r_reg.st == ST_SLEEP);
  c_noop_sleep: cover property (sleep_exec && r_reg.st == ST_RUN && irq_pending);
  c_isr_wake: cover property (isr_call);
  c_wdt_wake: cover property (r_reg.st == ST_SLEEP && wdt_expire);
endmodule
